// [hw/sadc_pkg.sv]
/*
  Shared constants and types for the converter control block.
  Assumes one clock domain; the analog macro answers on that same clock.
*/
package sadc_pkg;
  // Widths and FIFO depth
  localparam int RAW_W = 12;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 12;
  localparam int FIFO_W = ADDR_W + DATA_W;
  localparam int FIFO_DEPTH = 32;
  localparam int SH_MAX = 4;
  // Values after reset
  localparam logic RES12_RST = 1'b0;
  localparam logic [4:0] INPUT_RST = 5'h00;
  localparam logic [7:0] DIV_RST = 8'h00;
  localparam logic [4:0] SAMP_RST = 5'h00;
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [6:0] SLOT_RST = 7'h00;
  // Least sample time in converter clock periods
  localparam logic [4:0] SAMP_MIN = 5'h01;
  // Trigger source codes
  localparam logic [2:0] TRIG_MANUAL = 3'h0;
  localparam logic [2:0] TRIG_PIN = 3'h1;
  localparam logic [2:0] TRIG_TIMER = 3'h2;
  localparam logic [2:0] TRIG_AUTO = 3'h7;
  // Result format codes
  localparam logic [1:0] FMT_UINT = 2'h0;
  localparam logic [1:0] FMT_SINT = 2'h1;
  localparam logic [1:0] FMT_UFRAC = 2'h2;
  localparam logic [1:0] FMT_SFRAC = 2'h3;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SAMPLE = 4'h2,
    ST_CONV = 4'h4,
    ST_WRITE = 4'h8
  } sadc_state_t;
endpackage : sadc_pkg

// [hw/sadc_stream_if.sv]
/*
  Valid/ready word channel between the control logic and its result FIFO.
  Assumes both ends share one clock.
*/
`timescale 1ns/1ps
interface sadc_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : sadc_stream_if

// [hw/sadc_fifo.sv]
/*
  Flip-flop FIFO with valid/ready on both sides.
  Assumes the source holds data while valid and not ready.
*/
`timescale 1ns/1ps
module sadc_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Fill and drain sides
  sadc_stream_if.snk s_in,
  sadc_stream_if.src s_out
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q, wr_d, rd_q, rd_d;
  logic full, empty, push, pop;

  always_comb begin
    empty = (wr_q == rd_q);
    full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    push = s_in.valid && !full;
    pop = s_out.ready && !empty;
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
  end

  assign s_in.ready = !full;
  assign s_out.valid = !empty;
  assign s_out.data = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= s_in.data;
    end
  end
endmodule : sadc_fifo

// [hw/sadc_addr_gen.sv]
/*
  DMA address generator: stand-alone order or scatter/gather slots.
  Assumes i_step pulses once per result written.
*/
`timescale 1ns/1ps
module sadc_addr_gen (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Control
  input wire logic i_clear,
  input wire logic i_step,
  input wire logic [4:0] i_input_idx,
  input wire logic [3:0] i_interval,
  input wire logic [2:0] i_buf_size_log2,
  input wire logic i_build_mode,
  // Results
  output logic [sadc_pkg::ADDR_W-1:0] o_addr,
  output logic o_block_end
);
  import sadc_pkg::*;
  logic [3:0] cnt_q, cnt_d;
  logic [6:0] slot_q, slot_d, mask;
  logic [7:0] size;
  logic [ADDR_W-1:0] sg;

  always_comb begin
    size = 8'h01 << i_buf_size_log2;
    mask = 7'(size - 8'h01);
    o_block_end = i_step && (cnt_q == i_interval);
    sg = (ADDR_W'(i_input_idx) << i_buf_size_log2) + ADDR_W'(slot_q & mask);
    o_addr = i_build_mode ? ADDR_W'(cnt_q) : sg;
    cnt_d = cnt_q;
    slot_d = slot_q;
    if (i_clear) begin
      cnt_d = CNT_RST;
      slot_d = SLOT_RST;
    end else if (i_step) begin
      cnt_d = o_block_end ? CNT_RST : cnt_q + 4'h1;
      slot_d = o_block_end ? (slot_q + 7'h01) & mask : slot_q;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cnt_q <= CNT_RST;
      slot_q <= SLOT_RST;
    end else begin
      cnt_q <= cnt_d;
      slot_q <= slot_d;
    end
  end

  a_slot_advance: assert property (@(posedge i_clk) disable iff (i_srst)
    o_block_end && !i_clear |=> slot_q == (($past(slot_q) + 7'h01) & $past(mask)))
    else $error("slot count did not advance at interval end");
  a_seq_addr: assert property (@(posedge i_clk) disable iff (i_srst)
    i_build_mode |-> o_addr == ADDR_W'(cnt_q))
    else $error("ordered address differs from result count");
endmodule : sadc_addr_gen

// [hw/sadc_ctrl.sv]
/*
  Control and result delivery for one successive-approximation converter.
  Instantiate once per converter; each copy keeps its own settings.
  Assumes config ports share i_clk; only the trigger pin is asynchronous.
*/
`timescale 1ns/1ps
module sadc_ctrl (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Configuration
  input wire logic i_module_on,
  input wire logic i_resolution_select,
  input wire logic [2:0] i_vref_select,
  input wire logic [7:0] i_conv_clk_div,
  input wire logic [1:0] i_sh_channels,
  input wire logic [2:0] i_trig_source,
  input wire logic [4:0] i_sample_time,
  input wire logic [1:0] i_result_format,
  input wire logic [3:0] i_pointer_increment_interval,
  input wire logic i_dma_buffer_build_mode,
  input wire logic [2:0] i_dma_buf_size_log2,
  input wire logic i_scan_enable,
  input wire logic [31:0] i_pin_analog_select,
  input wire logic [4:0] i_ch0_input,
  // Triggers and flag clear
  input wire logic i_manual_trig,
  input wire logic i_timer_trig,
  input wire logic i_ext_trig_pin,
  input wire logic i_done_flag_clear,
  // Analog macro
  output logic [2:0] o_vref_select,
  output logic o_conv_clk_tick,
  output logic o_conv_12bit,
  output logic [sadc_pkg::SH_MAX-1:0] o_sh_sample,
  output logic o_conv_start,
  output logic [4:0] o_conv_input,
  input wire logic i_conv_done,
  input wire logic [sadc_pkg::RAW_W-1:0] i_conv_raw,
  // DMA and interrupt side
  output logic o_conv_done_flag,
  output logic o_dma_req,
  output logic o_dma_valid,
  output logic [sadc_pkg::DATA_W-1:0] o_dma_data,
  output logic [sadc_pkg::ADDR_W-1:0] o_dma_addr,
  input wire logic i_dma_ready
);
  import sadc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [2:0] sh_used(input logic res12, input logic [1:0] chps);
    if (res12) begin
      return 3'h1;
    end
    case (chps)
      2'h0: return 3'h1;
      2'h1: return 3'h2;
      default: return 3'h4;
    endcase
  endfunction : sh_used

  function automatic logic [4:0] next_scan(input logic [4:0] cur, input logic [31:0] sel);
    logic [4:0] r;
    logic f;
    logic [4:0] k;
    r = cur;
    f = 1'b0;
    for (int i = 1; i <= 32; i++) begin
      k = cur + 5'(i);
      if (!f && sel[k]) begin
        r = k;
        f = 1'b1;
      end
    end
    return r;
  endfunction : next_scan

  function automatic logic [DATA_W-1:0] fmt(input logic [RAW_W-1:0] raw, input logic res12,
                                             input logic [1:0] code);
    logic [11:0] v;
    v = res12 ? raw : {2'h0, raw[9:0]};
    case (code)
      FMT_SINT: return res12 ? {{5{~v[11]}}, v[10:0]} : {{7{~v[9]}}, v[8:0]};
      FMT_UFRAC: return res12 ? {v, 4'h0} : {v[9:0], 6'h00};
      FMT_SFRAC: return res12 ? {~v[11], v[10:0], 4'h0} : {~v[9], v[8:0], 6'h00};
      default: return {4'h0, v};
    endcase
  endfunction : fmt

  ////////////////////////////////////////////////////////////////////////////
  // Settings, trigger pin synchroniser, converter clock divider

  logic on_q, on_d, res12_q, res12_d;
  logic [2:0] vref_q, vref_d;
  logic pin_m_q, pin_s_q, pin_p_q;
  logic [7:0] div_q, div_d;
  logic tick_q, tick_d;
  logic trig;

  always_comb begin
    on_d = i_module_on;
    res12_d = on_q ? res12_q : i_resolution_select;
    vref_d = i_vref_select;
    // Compare with >= so that lowering the divider never waits for a wrap
    tick_d = (div_q >= i_conv_clk_div);
    div_d = tick_d ? DIV_RST : div_q + 8'h01;
    case (i_trig_source)
      TRIG_PIN: trig = pin_s_q && !pin_p_q;
      TRIG_TIMER: trig = i_timer_trig;
      default: trig = i_manual_trig;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      on_q <= 1'b0;
      res12_q <= RES12_RST;
      vref_q <= 3'h0;
      pin_m_q <= 1'b0;
      pin_s_q <= 1'b0;
      pin_p_q <= 1'b0;
      div_q <= DIV_RST;
      tick_q <= 1'b0;
    end else begin
      on_q <= on_d;
      res12_q <= res12_d;
      vref_q <= vref_d;
      pin_m_q <= i_ext_trig_pin;
      pin_s_q <= pin_m_q;
      pin_p_q <= pin_s_q;
      div_q <= div_d;
      tick_q <= tick_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  sadc_stream_if #(.W(FIFO_W)) push_if ();
  sadc_stream_if #(.W(FIFO_W)) pop_if ();

  sadc_state_t st_q, st_d;
  logic [1:0] ch_q, ch_d;
  logic [4:0] scan_q, scan_d, samp_q, samp_d, samp_need, in_sel, scan_cur;
  logic start_q, start_d;
  logic [DATA_W-1:0] data_q, data_d;
  logic [ADDR_W-1:0] addr_q, addr_d, gen_addr;
  logic step, last, block_end;

  always_comb begin
    st_d = st_q;
    ch_d = ch_q;
    scan_d = scan_q;
    samp_d = samp_q;
    start_d = 1'b0;
    data_d = data_q;
    addr_d = addr_q;
    samp_need = (i_sample_time < SAMP_MIN) ? SAMP_MIN : i_sample_time;
    // Scan position resolves to a selected input whenever at least one input is selected
    scan_cur = i_pin_analog_select[scan_q] ? scan_q : next_scan(scan_q, i_pin_analog_select);
    step = (st_q == ST_WRITE) && push_if.ready;
    last = (3'(ch_q) + 3'h1 >= sh_used(res12_q, i_sh_channels));
    case (st_q)
      ST_IDLE: begin
        samp_d = SAMP_RST;
        ch_d = 2'h0;
        if (on_q) begin
          st_d = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        if (tick_q && samp_q != 5'h1f) begin
          samp_d = samp_q + 5'h01;
        end
        if ((i_trig_source == TRIG_AUTO) ? (samp_q >= samp_need) : trig) begin
          st_d = ST_CONV;
          start_d = 1'b1;
        end
      end
      ST_CONV: begin
        if (i_conv_done) begin
          data_d = fmt(i_conv_raw, res12_q, i_result_format);
          addr_d = gen_addr;
          st_d = ST_WRITE;
        end
      end
      ST_WRITE: begin
        if (step && !last) begin
          ch_d = ch_q + 2'h1;
          st_d = ST_CONV;
          start_d = 1'b1;
        end else if (step) begin
          ch_d = 2'h0;
          samp_d = SAMP_RST;
          if (i_scan_enable) begin
            scan_d = next_scan(scan_cur, i_pin_analog_select);
          end
          st_d = ST_SAMPLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
    if (!on_q) begin
      st_d = ST_IDLE;
      start_d = 1'b0;
    end
    // Input of the channel converted next, so it registers with the start pulse
    if (ch_d != 2'h0) begin
      in_sel = 5'(ch_d);
    end else if (!i_scan_enable) begin
      in_sel = i_ch0_input;
    end else if (i_pin_analog_select[scan_d]) begin
      in_sel = scan_d;
    end else begin
      in_sel = next_scan(scan_d, i_pin_analog_select);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_q <= ST_IDLE;
      ch_q <= 2'h0;
      scan_q <= INPUT_RST;
      samp_q <= SAMP_RST;
      start_q <= 1'b0;
      data_q <= '0;
      addr_q <= '0;
    end else begin
      st_q <= st_d;
      ch_q <= ch_d;
      scan_q <= scan_d;
      samp_q <= samp_d;
      start_q <= start_d;
      data_q <= data_d;
      addr_q <= addr_d;
    end
  end

  assign push_if.valid = (st_q == ST_WRITE);
  assign push_if.data = {addr_q, data_q};

  sadc_addr_gen u_addr (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_clear(!on_q),
    .i_step(step),
    .i_input_idx(in_sel),
    .i_interval(i_pointer_increment_interval),
    .i_buf_size_log2(i_dma_buf_size_log2),
    .i_build_mode(i_dma_buffer_build_mode),
    .o_addr(gen_addr),
    .o_block_end(block_end)
  );

  sadc_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .s_in(push_if),
    .s_out(pop_if)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs: done flag, DMA stage, analog controls

  logic flag_q, flag_d, req_q, req_d, ov_q, ov_d;
  logic [FIFO_W-1:0] od_q, od_d;
  logic [SH_MAX-1:0] sh_q, sh_d;
  logic [4:0] inp_q, inp_d;

  always_comb begin
    flag_d = (flag_q && !i_done_flag_clear) || block_end;
    req_d = block_end;
    pop_if.ready = !ov_q || i_dma_ready;
    ov_d = pop_if.ready ? pop_if.valid : ov_q;
    od_d = (pop_if.ready && pop_if.valid) ? pop_if.data : od_q;
    sh_d = '0;
    if (st_q == ST_SAMPLE) begin
      for (int k = 0; k < SH_MAX; k++) begin
        sh_d[k] = (3'(k) < sh_used(res12_q, i_sh_channels));
      end
    end
    inp_d = in_sel;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      flag_q <= 1'b0;
      req_q <= 1'b0;
      ov_q <= 1'b0;
      od_q <= '0;
      sh_q <= '0;
      inp_q <= INPUT_RST;
    end else begin
      flag_q <= flag_d;
      req_q <= req_d;
      ov_q <= ov_d;
      od_q <= od_d;
      sh_q <= sh_d;
      inp_q <= inp_d;
    end
  end

  assign o_vref_select = vref_q;
  assign o_conv_clk_tick = tick_q;
  assign o_conv_12bit = res12_q;
  assign o_sh_sample = sh_q;
  assign o_conv_start = start_q;
  assign o_conv_input = inp_q;
  assign o_conv_done_flag = flag_q;
  assign o_dma_req = req_q;
  assign o_dma_valid = ov_q;
  assign o_dma_addr = od_q[FIFO_W-1:DATA_W];
  assign o_dma_data = od_q[DATA_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_word_out;
    (st_q == ST_WRITE) && push_if.ready;
  endsequence
  sequence s_event_end;
    s_word_out ##0 last;
  endsequence

  a_res_held_on: assert property (@(posedge i_clk) disable iff (i_srst)
    on_q && $past(on_q) |-> $stable(res12_q))
    else $error("resolution changed while module on");
  a_single_sh: assert property (@(posedge i_clk) disable iff (i_srst)
    res12_q |-> ch_q == 2'h0 && sh_q[SH_MAX-1:1] == '0)
    else $error("more than one sample/hold used in 12-bit mode");
  a_quad_walk: assert property (@(posedge i_clk) disable iff (i_srst)
    s_word_out ##0 (!last && on_q) |=> st_q == ST_CONV && start_q && ch_q == $past(ch_q) + 2'h1)
    else $error("next sample/hold channel not converted");
  a_scan_step: assert property (@(posedge i_clk) disable iff (i_srst)
    s_event_end ##0 (on_q && i_scan_enable)
    |=> scan_q == next_scan($past(scan_cur), $past(i_pin_analog_select)))
    else $error("scan did not step to the next selected input");
  a_vref_follow: assert property (@(posedge i_clk) disable iff (i_srst)
    1'b1 |=> o_vref_select == $past(i_vref_select))
    else $error("reference select not forwarded");
  a_tad_period: assert property (@(posedge i_clk) disable iff (i_srst)
    tick_q && i_conv_clk_div == 8'h01 ##1 i_conv_clk_div == 8'h01
    |-> !tick_q ##1 tick_q)
    else $error("converter clock period wrong");
  a_sh_count: assert property (@(posedge i_clk) disable iff (i_srst)
    s_event_end |-> 3'(ch_q) + 3'h1 == sh_used(res12_q, i_sh_channels))
    else $error("wrong number of sample/hold channels per event");
  a_manual_start: assert property (@(posedge i_clk) disable iff (i_srst)
    st_q == ST_SAMPLE && on_q && i_trig_source == TRIG_MANUAL && i_manual_trig
    |=> st_q == ST_CONV && start_q ##1 !start_q)
    else $error("trigger did not start one conversion");
  a_fmt_result: assert property (@(posedge i_clk) disable iff (i_srst)
    st_q == ST_CONV && i_conv_done && on_q
    |=> push_if.valid && push_if.data[DATA_W-1:0] ==
        fmt($past(i_conv_raw), res12_q, $past(i_result_format)))
    else $error("result not formatted as selected");
  a_flag_req: assert property (@(posedge i_clk) disable iff (i_srst)
    block_end |=> o_conv_done_flag && o_dma_req ##1 !o_dma_req)
    else $error("done flag or DMA request missing");
  a_flag_set_wins: assert property (@(posedge i_clk) disable iff (i_srst)
    block_end && i_done_flag_clear |=> o_conv_done_flag)
    else $error("flag set lost to a clear");
endmodule : sadc_ctrl

// [sim/sadc_far_model.sv]
/*
  Far-side model: analog macro answering conversions, and a DMA sink.
  Assumes one clock shared with the control block.
*/
`timescale 1ns/1ps
module sadc_far_model (
  // Clock, reset and sink stall
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_stall,
  // Analog macro side
  input wire logic i_conv_start,
  input wire logic [4:0] i_conv_input,
  input wire logic [sadc_pkg::SH_MAX-1:0] i_sh_sample,
  output logic o_conv_done,
  output logic [sadc_pkg::RAW_W-1:0] o_conv_raw,
  // DMA side
  input wire logic i_dma_req,
  input wire logic i_dma_valid,
  input wire logic [sadc_pkg::DATA_W-1:0] i_dma_data,
  input wire logic [sadc_pkg::ADDR_W-1:0] i_dma_addr,
  output logic o_dma_ready
);
  import sadc_pkg::*;
  logic [4:0] in_q[$];
  logic [DATA_W-1:0] data_q[$];
  logic [ADDR_W-1:0] addr_q[$];
  logic [4:0] cur_in = 5'h00;
  int starts = 0;
  int reqs = 0;
  int sh_max = 0;
  int wait_cnt = 0;
  initial begin
    o_conv_done = 1'b0;
    o_conv_raw = 12'h000;
    o_dma_ready = 1'b0;
  end
  always @(posedge i_clk) begin
    o_conv_done <= 1'b0;
    o_dma_ready <= !i_stall;
    // Result lines keep changing outside the done pulse
    o_conv_raw <= ~o_conv_raw;
    if (i_srst) begin
      wait_cnt <= 0;
    end else if (i_conv_start) begin
      starts++;
      in_q.push_back(i_conv_input);
      cur_in <= i_conv_input;
      wait_cnt <= 3;
    end else if (wait_cnt == 1) begin
      o_conv_done <= 1'b1;
      o_conv_raw <= {cur_in, 7'h2a};
      wait_cnt <= 0;
    end else if (wait_cnt > 1) begin
      wait_cnt <= wait_cnt - 1;
    end
    if (i_dma_valid && o_dma_ready) begin
      data_q.push_back(i_dma_data);
      addr_q.push_back(i_dma_addr);
    end
    if (i_dma_req) begin
      reqs++;
    end
    if ($countones(i_sh_sample) > sh_max) begin
      sh_max = $countones(i_sh_sample);
    end
  end
endmodule : sadc_far_model

// [sim/sadc_ctrl_test.sv]
/*
  Self-checking bench for the converter control block.
  Assumes the far-side model answers conversions and sinks DMA words.
*/
`timescale 1ns/1ps
module sadc_ctrl_test;
  import sadc_pkg::*;
  logic i_clk = 1'b0, i_srst = 1'b1, i_module_on = 1'b0, i_resolution_select = 1'b0;
  logic [2:0] i_vref_select = 3'h0, i_trig_source = TRIG_MANUAL, i_dma_buf_size_log2 = 3'h0;
  logic [7:0] i_conv_clk_div = 8'h00;
  logic [1:0] i_sh_channels = 2'h0, i_result_format = FMT_UINT;
  logic [4:0] i_sample_time = 5'h01, i_ch0_input = 5'h00;
  logic [3:0] i_pointer_increment_interval = 4'h0;
  logic i_dma_buffer_build_mode = 1'b1, i_scan_enable = 1'b0, i_manual_trig = 1'b0;
  logic i_timer_trig = 1'b0, i_ext_trig_pin = 1'b0, i_done_flag_clear = 1'b0, stall = 1'b0;
  logic [31:0] i_pin_analog_select = 32'h0000_0000;
  logic [2:0] o_vref_select;
  logic o_conv_clk_tick, o_conv_12bit, o_conv_start, o_conv_done_flag, o_dma_req, o_dma_valid;
  logic [SH_MAX-1:0] o_sh_sample;
  logic [4:0] o_conv_input;
  logic i_conv_done, i_dma_ready;
  logic [RAW_W-1:0] i_conv_raw;
  logic [DATA_W-1:0] o_dma_data;
  logic [ADDR_W-1:0] o_dma_addr;
  int fails = 0;
  int tests_run = 0;

  initial begin
    forever #12.5 i_clk = ~i_clk;
  end

  sadc_ctrl dut_u (
    .i_clk, .i_srst, .i_module_on, .i_resolution_select, .i_vref_select, .i_conv_clk_div,
    .i_sh_channels, .i_trig_source, .i_sample_time, .i_result_format,
    .i_pointer_increment_interval, .i_dma_buffer_build_mode, .i_dma_buf_size_log2,
    .i_scan_enable, .i_pin_analog_select, .i_ch0_input, .i_manual_trig, .i_timer_trig,
    .i_ext_trig_pin, .i_done_flag_clear, .o_vref_select, .o_conv_clk_tick, .o_conv_12bit,
    .o_sh_sample, .o_conv_start, .o_conv_input, .i_conv_done, .i_conv_raw,
    .o_conv_done_flag, .o_dma_req, .o_dma_valid, .o_dma_data, .o_dma_addr, .i_dma_ready
  );
  sadc_far_model far_u (
    .i_clk, .i_srst, .i_stall(stall), .i_conv_start(o_conv_start),
    .i_conv_input(o_conv_input), .i_sh_sample(o_sh_sample), .o_conv_done(i_conv_done),
    .o_conv_raw(i_conv_raw), .i_dma_req(o_dma_req), .i_dma_valid(o_dma_valid),
    .i_dma_data(o_dma_data), .i_dma_addr(o_dma_addr), .o_dma_ready(i_dma_ready)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_count(input int got, input int exp);
    tests_run++;
    if (got != exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_count
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask : cyc
  task automatic set_on(input logic on);
    i_module_on = on;
    cyc(4);
  endtask : set_on
  function automatic logic [15:0] exp_data(input logic [4:0] in, input logic res12);
    return res12 ? {4'h0, in, 7'h2a} : {6'h00, in[2:0], 7'h2a};
  endfunction : exp_data
  // One manual trigger, then wait for the event's words at the sink
  task automatic fire(input int words);
    int target;
    int n;
    target = far_u.data_q.size() + words;
    i_manual_trig = 1'b1;
    cyc(1);
    i_manual_trig = 1'b0;
    n = 0;
    while (far_u.data_q.size() < target && n < 200) begin
      cyc(1);
      n++;
    end
    cyc(3);
    chk_count(far_u.data_q.size(), target);
  endtask : fire

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk_word(16'(o_conv_12bit), 16'h0000);
    chk_word(16'(o_conv_done_flag), 16'h0000);
    i_vref_select = 3'h5;
    cyc(2);
    chk_word(16'(o_vref_select), 16'h0005);
    $display("Test reset done");
  endtask : t_reset
  task automatic t_resolution;
    i_resolution_select = 1'b1;
    cyc(2);
    chk_word(16'(o_conv_12bit), 16'h0001);
    set_on(1'b1);
    i_resolution_select = 1'b0;
    cyc(3);
    chk_word(16'(o_conv_12bit), 16'h0001);
    set_on(1'b0);
    chk_word(16'(o_conv_12bit), 16'h0000);
    $display("Test resolution done");
  endtask : t_resolution
  task automatic t_channels;
    i_sh_channels = 2'h3;
    i_ch0_input = 5'h07;
    set_on(1'b1);
    far_u.in_q.delete();
    far_u.sh_max = 0;
    fire(4);
    for (int i = 0; i < 4; i++) begin
      chk_word(16'(far_u.in_q[i]), (i == 0) ? 16'h0007 : 16'(i));
    end
    chk_count(far_u.sh_max, 4);
    set_on(1'b0);
    i_resolution_select = 1'b1;
    set_on(1'b1);
    far_u.in_q.delete();
    far_u.sh_max = 0;
    fire(1);
    chk_count(far_u.in_q.size(), 1);
    chk_count(far_u.sh_max, 1);
    chk_word(far_u.data_q[$], exp_data(5'h07, 1'b1));
    $display("Test channels done");
  endtask : t_channels
  task automatic t_ordered;
    int b;
    int r;
    set_on(1'b0);
    i_resolution_select = 1'b0;
    i_sh_channels = 2'h1;
    i_ch0_input = 5'h09;
    i_pointer_increment_interval = 4'h3;
    i_done_flag_clear = 1'b1;
    cyc(1);
    i_done_flag_clear = 1'b0;
    set_on(1'b1);
    b = far_u.data_q.size();
    r = far_u.reqs;
    fire(2);
    chk_word(16'(o_conv_done_flag), 16'h0000);
    fire(2);
    chk_word(16'(o_conv_done_flag), 16'h0001);
    chk_count(far_u.reqs - r, 1);
    for (int i = 0; i < 4; i++) begin
      chk_word(16'(far_u.addr_q[b + i]), 16'(i));
      chk_word(far_u.data_q[b + i], exp_data(i[0] ? 5'h01 : 5'h09, 1'b0));
    end
    i_done_flag_clear = 1'b1;
    cyc(1);
    i_done_flag_clear = 1'b0;
    cyc(1);
    chk_word(16'(o_conv_done_flag), 16'h0000);
    $display("Test ordered done");
  endtask : t_ordered
  task automatic t_scatter;
    int b;
    int r;
    set_on(1'b0);
    i_resolution_select = 1'b1;
    i_dma_buffer_build_mode = 1'b0;
    i_dma_buf_size_log2 = 3'h1;
    i_ch0_input = 5'h05;
    i_pointer_increment_interval = 4'h0;
    set_on(1'b1);
    b = far_u.addr_q.size();
    r = far_u.reqs;
    repeat (3) fire(1);
    chk_word(16'(far_u.addr_q[b]), 16'h000a);
    chk_word(16'(far_u.addr_q[b + 1]), 16'h000b);
    chk_word(16'(far_u.addr_q[b + 2]), 16'h000a);
    chk_count(far_u.reqs - r, 3);
    $display("Test scatter done");
  endtask : t_scatter
  task automatic t_scan_div;
    int n;
    set_on(1'b0);
    i_scan_enable = 1'b1;
    i_pin_analog_select = 32'h8000_0010;
    i_conv_clk_div = 8'h01;
    set_on(1'b1);
    far_u.in_q.delete();
    repeat (3) fire(1);
    chk_count(int'(far_u.in_q[0]) * int'(far_u.in_q[1]), 124);
    chk_count(int'(far_u.in_q[1]) * int'(far_u.in_q[2]), 124);
    n = 0;
    while (o_conv_clk_tick !== 1'b1 && n < 20) begin
      cyc(1);
      n++;
    end
    cyc(1);
    n = 1;
    while (o_conv_clk_tick !== 1'b1 && n < 20) begin
      cyc(1);
      n++;
    end
    chk_count(n, 2);
    $display("Test scan and divider done");
  endtask : t_scan_div
  task automatic t_fifo;
    int b;
    int s0;
    int s1;
    int n;
    set_on(1'b0);
    i_scan_enable = 1'b0;
    i_conv_clk_div = 8'h00;
    i_resolution_select = 1'b0;
    i_sh_channels = 2'h3;
    i_trig_source = TRIG_AUTO;
    stall = 1'b1;
    b = far_u.data_q.size();
    s0 = far_u.starts;
    set_on(1'b1);
    cyc(400);
    s1 = far_u.starts;
    cyc(100);
    chk_count(far_u.starts, s1);
    chk_count(int'(s1 - s0 >= FIFO_DEPTH), 1);
    i_trig_source = TRIG_MANUAL;
    stall = 1'b0;
    n = 0;
    while (o_dma_valid !== 1'b0 && n < 400) begin
      cyc(1);
      n++;
    end
    cyc(20);
    chk_count(far_u.data_q.size() - b, far_u.starts - s0);
    chk_word(16'(o_dma_valid), 16'h0000);
    $display("Test buffer done");
  endtask : t_fifo

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(negedge i_clk);
    i_srst = 1'b0;
    cyc(1);
    t_reset();
    t_resolution();
    t_channels();
    t_ordered();
    t_scatter();
    t_scan_div();
    t_fifo();
    test_done();
  end
  initial begin
    repeat (30000) @(posedge i_clk);
    fails++;
    $display("Error at %0t: watchdog expired", $time);
    test_done();
  end
endmodule : sadc_ctrl_test
